// ---- sar_pkg.sv ----
// constants, state codes and pin carrier for the converter control block
package sar_pkg;

	// result word
	localparam int          RES_W       = 18;
	localparam int          BIT_IDX_W   = 5;
	localparam logic [4:0]  BIT_LAST    = 5'h11;
	localparam logic [17:0] ABORT_CODE  = 18'h3fc00;
	localparam logic [17:0] RES_RESET   = 18'h00000;

	// two's complement code points of the result
	localparam logic [17:0] CODE_POS_FS = 18'h1ffff;
	localparam logic [17:0] CODE_MID    = 18'h00000;
	localparam logic [17:0] CODE_MID_M1 = 18'h3ffff;
	localparam logic [17:0] CODE_NEG_FS = 18'h20000;

	// timing: longest conversion time rounds down to whole cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS  = 1100;
	localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CNT_W    = 8;

	// conversion state machine, one-hot
	typedef enum logic [3:0] {
		ST_SAMPLE  = 4'h1,
		ST_CONVERT = 4'h2,
		ST_WAIT    = 4'h4,
		ST_NAP     = 4'h8
	} sar_state_t;

	// control pins as seen in the system domain
	typedef struct packed {
		logic cs_n;
		logic start_n;
		logic frame_sync;
		logic power_down;
	} sar_pins_t;

	// idle pin levels used as synchroniser reset value
	localparam logic [3:0] PINS_IDLE = 4'hc;

	// synchroniser depth
	localparam int SYNC_STAGES = 2;

endpackage

// ---- sar_sync.sv ----
// multi-bit two-stage level synchroniser into the system clock domain
`timescale 1ns/100ps

module sar_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_b,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] i_async,
	output      logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	initial begin
		if (WIDTH < 1) begin
			$error("sar_sync: WIDTH must be at least 1");
		end
	end

	// first stage is read only by the second stage
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

// ---- sar_conv_ctrl.sv ----
// conversion control and serial readout of the 18-bit sar converter
//
// Operation
// - qualified start follows start input only while chip select is low
// - falling edge of qualified start ends sampling and starts conversion
// - start high with chip select low starts sampling, even right after eoc
// - without sample start at end of conversion, go to wait or nap
// - qualified start low at end of conversion selects nap over wait
// - qualified start falling during conversion aborts it, then wait
// - an aborted conversion reads back as 0x3fc00
// - reads run independent of conversion; reads mid-conversion give prior
// - cs mode: msb on cs fall, next bits on rising edges after first fall
// - cs mode: chip select high then low restarts the frame at msb
// - fs mode: msb on fs rise, shifting after fs fall as in cs mode
// - fs mode: fs high at busy fall reloads output with new msb
// - fs mode: new fs rise restarts the frame at msb
// - conversion timed by internal clock, done within maximum time
// - busy is high exactly while a conversion is in progress
// - results are two's complement 18-bit codes
// - power-down high resets the state; low resumes operation
`timescale 1ns/100ps

module sar_conv_ctrl #(
	parameter int CONV_CYCLES = sar_pkg::CONV_CYCLES
) (
	// system clock and synchronous reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// serial clock from the host, clocks the readout shifter
	input  wire logic        i_sclk,
	// control pins from the host
	input  wire logic        i_cs_n,
	input  wire logic        i_conversion_start_n,
	input  wire logic        i_frame_sync,
	input  wire logic        i_power_down_pin,
	// comparator decision word from the analog core, system domain
	input  wire logic [17:0] i_conv_code,
	// status outputs
	output      logic        o_busy,
	output      logic        o_sampling,
	output      logic        o_nap,
	// serial result pin: data and output enable
	output      logic        o_serial_result_out,
	output      logic        o_serial_result_out_oe
);

	initial begin
		if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin
			$error("sar_conv_ctrl: CONV_CYCLES must lie in 2..255");
		end
	end

	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

	// pins into the system domain
	sar_pkg::sar_pins_t pins_raw;
	sar_pkg::sar_pins_t pins_s;
	logic               frame_act_raw;
	logic               frame_act_s;

	// conversion control state
	sar_pkg::sar_state_t state_q;
	sar_pkg::sar_state_t state_d;
	logic [7:0]          conv_cnt_q;
	logic [7:0]          conv_cnt_d;
	logic                qual_q;
	logic                qual_d;
	logic                qual_prev_q;
	logic                fs_mode_q;
	logic                fs_mode_d;

	// result words
	logic [17:0] result_q;
	logic [17:0] result_d;
	logic [17:0] out_word_q;
	logic [17:0] out_word_d;

	// decoded events
	wire in_convert  = (state_q == sar_pkg::ST_CONVERT);
	wire pd_s        = pins_s.power_down;
	wire qual_fall   = qual_prev_q & ~qual_q;
	wire sample_cmd  = pins_s.start_n & ~pins_s.cs_n;
	wire conv_done   = in_convert & (conv_cnt_q == CONV_LAST);
	wire abort_evt   = in_convert & qual_fall;
	wire eoc_evt     = conv_done & ~qual_fall;
	wire busy_fall   = eoc_evt | abort_evt;

	// readout domain signals
	logic [4:0] bit_q;
	logic       armed_q;
	wire        frame_clr;
	wire  [4:0] bit_sel;

	// gather the pins for one synchroniser
	assign pins_raw.cs_n       = i_cs_n;
	assign pins_raw.start_n    = i_conversion_start_n;
	assign pins_raw.frame_sync = i_frame_sync;
	assign pins_raw.power_down = i_power_down_pin;

	sar_sync #(
		.WIDTH   (4),
		.RST_VAL (sar_pkg::PINS_IDLE)
	) u_pin_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_async   (pins_raw),
		.o_sync    (pins_s)
	);

	// frame activity from the readout side, as a level
	sar_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b0)
	) u_frame_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_async   (frame_act_raw),
		.o_sync    (frame_act_s)
	);

	// qualified start: latched copy of start while cs is low
	always_comb begin
		qual_d = qual_q;
		if (!pins_s.cs_n) begin
			qual_d = pins_s.start_n;
		end
	end

	// frame-sync mode is recognised once fs is seen low during a select
	assign fs_mode_d = fs_mode_q | (~pins_s.frame_sync & ~pins_s.cs_n);

	// next state of the conversion sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			sar_pkg::ST_SAMPLE: begin
				if (qual_fall) begin
					state_d = sar_pkg::ST_CONVERT;
				end
			end
			sar_pkg::ST_CONVERT: begin
				if (qual_fall) begin
					state_d = sar_pkg::ST_WAIT;
				end else if (conv_done) begin
					if (sample_cmd) begin
						state_d = sar_pkg::ST_SAMPLE;
					end else if (!qual_q) begin
						state_d = sar_pkg::ST_NAP;
					end else begin
						state_d = sar_pkg::ST_WAIT;
					end
				end
			end
			sar_pkg::ST_WAIT, sar_pkg::ST_NAP: begin
				if (sample_cmd) begin
					state_d = sar_pkg::ST_SAMPLE;
				end
			end
			default: begin
				state_d = sar_pkg::ST_WAIT;
			end
		endcase
	end

	// conversion timer runs only while converting, off the system clock
	assign conv_cnt_d = (state_d == sar_pkg::ST_CONVERT && in_convert) ?
		conv_cnt_q + 8'h01 : 8'h00;

	// result capture: decision word at eoc, fixed code after abort
	always_comb begin
		result_d = result_q;
		if (abort_evt) begin
			result_d = sar_pkg::ABORT_CODE;
		end else if (eoc_evt) begin
			result_d = i_conv_code;
		end
	end

	// the readout word only moves while no frame is shifting, so the
	// serial clock never samples it mid-change; a frame that straddles
	// busy fall keeps the older sample
	assign out_word_d = frame_act_s ? out_word_q : result_q;

	// sequencer registers; power-down acts like reset while high
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b || pd_s) begin
			state_q    <= sar_pkg::ST_WAIT;
			conv_cnt_q <= 8'h00;
			qual_q     <= 1'b1;
			qual_prev_q <= 1'b1;
			fs_mode_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			conv_cnt_q <= conv_cnt_d;
			qual_q     <= qual_d;
			qual_prev_q <= qual_q;
			fs_mode_q  <= fs_mode_d;
		end
	end

	// result registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b || pd_s) begin
			result_q   <= sar_pkg::RES_RESET;
			out_word_q <= sar_pkg::RES_RESET;
		end else begin
			result_q   <= result_d;
			out_word_q <= out_word_d;
		end
	end

	// status straight from the state register
	assign o_busy     = state_q[1];
	assign o_sampling = state_q[0];
	assign o_nap      = state_q[3];

	// readout side: frame cleared by cs high, or by fs high in fs mode;
	// fs high holds the msb, so its rise and any re-rise restart at msb
	assign frame_clr = i_cs_n | i_power_down_pin |
		(fs_mode_q & i_frame_sync);
	assign frame_act_raw = ~frame_clr;

	// a falling serial clock edge must be seen before shifting begins
	always_ff @(negedge i_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	// bit index advances on each rising edge once armed, stops at lsb
	always_ff @(posedge i_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			bit_q <= 5'h00;
		end else if (armed_q && bit_q != sar_pkg::BIT_LAST) begin
			bit_q <= bit_q + 5'h01;
		end
	end

	// msb first; the lsb stays on the pin if the host clocks on
	assign bit_sel = sar_pkg::BIT_LAST - bit_q;

	// with fs high the index sits at zero, so a new word loaded at busy
	// fall shows its msb at once
	assign o_serial_result_out = out_word_q[bit_sel];

	// pin floats while deselected or powered down
	assign o_serial_result_out_oe = ~i_cs_n & ~i_power_down_pin;

endmodule

// ---- sar_conv_ctrl_asserts.sv ----
// concurrent checks on the converter control ports
`timescale 1ns/100ps
module sar_conv_ctrl_asserts #(
	parameter int CONV_CYCLES = 110
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// host pins
	input wire logic i_cs_n,
	input wire logic i_conversion_start_n,
	input wire logic i_power_down_pin,
	// status and pin enable
	input wire logic o_busy,
	input wire logic o_sampling,
	input wire logic o_nap,
	input wire logic o_serial_result_out_oe
);
	logic [7:0] busy_cnt_q;
	logic [7:0] busy_cnt_d;
	// length of the busy run so far, clears when busy drops
	assign busy_cnt_d = o_busy ? busy_cnt_q + 8'h01 : 8'h00;
	always_ff @(posedge i_clk_sys)
		busy_cnt_q <= i_rst_b ? busy_cnt_d : 8'h00;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	// qualified start falls while sampling, or while converting
	sequence s_start_fall;
		o_sampling && !i_cs_n && $fell(i_conversion_start_n);
	endsequence
	sequence s_abort_fall;
		o_busy && !i_cs_n && $fell(i_conversion_start_n);
	endsequence
	a_oe_follows_cs: assert property (
		o_serial_result_out_oe == (!i_cs_n && !i_power_down_pin))
		else $error("output enable not following select");
	a_state_onehot: assert property (
		$onehot0({o_busy, o_sampling, o_nap})) else $error("states overlap");
	a_busy_from_sample: assert property (
		$rose(o_busy) |-> $past(o_sampling)) else $error("busy not from sample");
	a_busy_bounded: assert property (
		o_busy |-> busy_cnt_q < CONV_CYCLES) else $error("conversion too long");
	a_nap_at_eoc: assert property (
		$rose(o_nap) |-> $past(o_busy)) else $error("nap entered off eoc");
	a_sample_cond: assert property (
		$rose(o_sampling) |-> $past(!i_cs_n && i_conversion_start_n, 3))
		else $error("sampling without start command");
	a_select_gates: assert property (
		i_cs_n [*5] |=> !$rose(o_busy) && !$rose(o_sampling))
		else $error("start taken with select high");
	a_start_to_busy: assert property (
		s_start_fall |-> ##[2:5] o_busy) else $error("conversion did not start");
	a_abort_to_wait: assert property (
		s_abort_fall |-> ##[2:6] !(o_busy || o_nap || o_sampling))
		else $error("abort did not reach wait");
endmodule
bind sar_conv_ctrl sar_conv_ctrl_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cs_n(i_cs_n),
	.i_conversion_start_n(i_conversion_start_n),
	.i_power_down_pin(i_power_down_pin), .o_busy(o_busy),
	.o_sampling(o_sampling), .o_nap(o_nap),
	.o_serial_result_out_oe(o_serial_result_out_oe));

// ---- sar_host_model.sv ----
// host serial controller model: select, start, frame sync and link clock
`timescale 1ns/100ps
module sar_host_model (
	// pins towards the converter
	output logic      o_cs_n,
	output logic      o_start_n,
	output logic      o_fs,
	output logic      o_sclk,
	// serial data back
	input  wire logic i_sdo
);
	localparam int HALF = 24; // half of the 48 ns link clock
	// idle levels; link clock stands still outside frames
	initial begin
		o_cs_n = 1'b1;
		o_start_n = 1'b1;
		o_fs = 1'b1;
		o_sclk = 1'b0;
	end
	// one read frame of nb bits, framed by select or by frame sync
	task automatic rd(input logic fsm, input int nb, output logic [17:0] w);
		w = 18'h00000;
		if (fsm) begin
			o_fs = 1'b0;
			#(2 * HALF) o_fs = 1'b1;
		end else
			o_cs_n = 1'b0;
		#(2 * HALF) w[17] = i_sdo;
		o_fs = ~fsm; // select framing keeps frame sync high
		#HALF o_sclk = 1'b1;
		#HALF o_sclk = 1'b0;
		for (int k = 16; k > 17 - nb; k--) begin
			#HALF o_sclk = 1'b1;
			#HALF w[k] = i_sdo;
			o_sclk = 1'b0;
		end
		#HALF o_cs_n = o_cs_n | ~fsm;
		#(2 * HALF);
	endtask
endmodule

// ---- tb_sar_adc_conversion_and_readout.sv ----
// self-checking bench for conversion control and serial readout
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
	mismatches++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb_sar_adc_conversion_and_readout;
	localparam int CONV = 12;
	logic        clk = 1'b0;
	logic        rst_b, pd, busy, smp, nap, serial_result_out, oe, pin, cs_n, start_n, fs, sclk;
	logic [17:0] code, exp_w, w;
	logic [17:0] tbl [4] = '{sar_pkg::CODE_POS_FS, sar_pkg::CODE_NEG_FS,
		sar_pkg::CODE_MID, sar_pkg::CODE_MID_M1};
	logic [31:0] rnd = 32'h00013395;
	int          mismatches = 0, n_compared = 0, cyc = 0;
	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	// a released pin shows the inverse, never a stale bit
	assign pin = oe ? serial_result_out : ~serial_result_out;
	sar_host_model host_u (.o_cs_n(cs_n), .o_start_n(start_n), .o_fs(fs),
		.o_sclk(sclk), .i_sdo(pin));
	sar_conv_ctrl #(.CONV_CYCLES(CONV)) dut_u (.i_clk_sys(clk),
		.i_rst_b(rst_b), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_conversion_start_n(start_n), .i_frame_sync(fs),
		.i_power_down_pin(pd), .i_conv_code(code), .o_busy(busy),
		.o_sampling(smp), .o_nap(nap), .o_serial_result_out(serial_result_out),
		.o_serial_result_out_oe(oe));
	task automatic test_done;
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// one conversion; m: 0 nap, 1 back to back, 2 abort, 3 frame sync
	task automatic conv(input int m, input logic [17:0] c);
		int n;
		code = c;
		host_u.o_cs_n = 1'b0;
		host_u.o_start_n = 1'b1;
		if (m == 3) host_u.o_fs = 1'b1;
		tick(6);
		`CHK("sampling", 1'b1, smp)
		host_u.o_start_n = 1'b0;
		n = 0;
		while (busy !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
		if (m == 0) host_u.o_cs_n = 1'b1;
		if (m == 1 || m == 2) host_u.o_start_n = 1'b1;
		// abort needs the second fall seen while select is still low
		for (n = 0; busy === 1'b1 && n < 40; n++) begin
			tick(1);
			if (m == 2 && n == 2) host_u.o_start_n = 1'b0;
			if (m == 2 && n == 4) host_u.o_cs_n = 1'b1;
		end
		exp_w = (m == 2) ? sar_pkg::ABORT_CODE : c;
		if (m == 2) `CHK("aborted", 1'b1, 1'(n < CONV))
		else `CHK("busy cycles", CONV, n)
		tick(4);
		`CHK("state", (m == 1) ? 2'b10 : (m == 2) ? 2'b00 : 2'b01,
			{smp, nap})
		if (m == 3) `CHK("reload msb", exp_w[17], serial_result_out)
		if (m != 1) begin
			// frames start well clear of busy fall
			host_u.rd(m == 3, 5, w);
			host_u.rd(m == 3, 18, w);
			`CHK("word", exp_w, w)
		end
	endtask
	// main sequence
	initial begin
		rst_b = 1'b0;
		pd = 1'b0;
		code = 18'h00000;
		tick(3);
		rst_b = 1'b1;
		for (int i = 0; i < 7; i++) begin
			rnd = xs(rnd);
			conv((i == 2) ? 2 : (i == 4) ? 1 : 0, (i < 4) ? tbl[i] : rnd[17:0]);
		end
		host_u.o_start_n = 1'b1;
		tick(4);
		host_u.o_start_n = 1'b0;
		tick(6);
		`CHK("ignored", 2'b01, {busy, nap})
		host_u.o_fs = 1'b0;
		host_u.o_cs_n = 1'b0;
		tick(6);
		conv(3, ~exp_w);
		host_u.o_start_n = 1'b1;
		tick(6);
		host_u.o_start_n = 1'b0;
		tick(6);
		pd = 1'b1;
		tick(4);
		`CHK("power down", 2'b00, {busy, oe})
		pd = 1'b0;
		test_done();
	end
endmodule
